// ### logic/ret_rot_pkg.sv
/*
  Shared constants and carriers for the return and rotate execution unit.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
`default_nettype none
package ret_rot_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [13:0] RETURN_CODE  = 14'h0008; // Return from subroutine
  localparam logic [13:0] RETFI_CODE   = 14'h0009; // Return from interrupt
  localparam logic [5:0]  RETLIT_HI    = 6'h34;    // Upper bits, literal return
  localparam logic [5:0]  ROTL_HI      = 6'h0D;    // Upper bits, rotate left
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT   = 7;  // Destination select bit
  localparam int IRQ_EN_POS = 7;  // Enable bit in interrupt control
  localparam int MSB_POS    = 7;  // Top data bit
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  W_RST       = 8'h00; // Working register reset
  localparam logic [7:0]  ICTL_RST    = 8'h00; // Interrupt control reset
  localparam logic [14:0] PC_RST      = 15'h0000; // Program counter reset
  localparam int          RET_CYCLES  = 2;     // Cycles of any return
  localparam int          ROT_CYCLES  = 1;     // Cycles of a rotate

  // Instruction class
  typedef enum logic [2:0] {
    OP_NONE, OP_RET, OP_RETFI, OP_RETLIT, OP_ROTL
  } op_kind_t;

  // Register file write request
  typedef struct packed {
    logic       en;   // Write strobe
    logic [6:0] addr; // Register index in bank
    logic [7:0] data; // Write data
  } file_wr_t;
endpackage
`default_nettype wire

// ### logic/ret_rot_decode.sv
/*
  Instruction classifier for the return and rotate unit.
  Assumes a registered instruction word presented with a valid strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module ret_rot_decode
  import ret_rot_pkg::*;
(
  input  wire logic [13:0]          instr,
  input  wire logic                 instr_valid,
  output var ret_rot_pkg::op_kind_t kind
);
  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  always_comb begin
    kind = OP_NONE;
    if (instr_valid) begin
      if (instr == RETURN_CODE) begin
        kind = OP_RET;
      end else if (instr == RETFI_CODE) begin
        kind = OP_RETFI;
      end else if (instr[13:8] == RETLIT_HI) begin
        kind = OP_RETLIT;
      end else if (instr[13:8] == ROTL_HI) begin
        kind = OP_ROTL;
      end
    end
  end
endmodule // ret_rot_decode
`default_nettype wire

// ### logic/return_and_rotate_exec.sv
/*
  Execution of the return group and rotate-left-through-carry.
  Assumes the core supplies instruction, stack top, file read data and
  carry, and holds the instruction stable until instr_ready is seen.
*/
// Overview of operation
// - Interrupt return pops stack into counter
// - Interrupt return sets global enable bit
// - Interrupt return takes two cycles
// - Subroutine return pops stack into counter
// - Subroutine return takes two cycles
// - Literal return writes literal to working register
// - Literal return pops stack, two cycles
// - Rotate left through carry, bit7 to carry
// - Destination bit picks working or file
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec
  import ret_rot_pkg::*;
#(
  parameter int PC_W = 15   // Program counter width
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic [13:0]        instr,
  input  wire logic               instr_valid,
  input  wire logic [PC_W-1:0]    stack_top_entry,
  input  wire logic [7:0]         file_rdata,
  input  wire logic               carry_in,
  output logic                    instr_ready,
  output logic                    stack_pop,
  output logic [PC_W-1:0]         pc_q,
  output logic                    pc_load,
  output logic [7:0]              w_q,
  output logic [7:0]              interrupt_control_reg,
  output logic                    carry_q,
  output logic                    carry_we,
  output var ret_rot_pkg::file_wr_t file_wr
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PC_W < 1 || PC_W > 15) begin : g_bad_pc
    $error("PC_W must be 1 to 15");
  end

  op_kind_t       kind;        // Decoded class
  logic           busy_q;      // Second cycle of a return
  logic [7:0]     rot_res;     // Rotated value
  logic           rot_carry;   // Carry out of rotate
  logic           global_irq_enable_bit; // Enable bit alias

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  ret_rot_decode u_dec (
    .instr       (instr),
    .instr_valid (instr_valid),
    .kind        (kind)
  );

  // Returns class test, used in several places
  function automatic logic is_return(input op_kind_t k);
    return (k == OP_RET) || (k == OP_RETFI) || (k == OP_RETLIT);
  endfunction

  assign rot_res   = {file_rdata[MSB_POS-1:0], carry_in};
  assign rot_carry = file_rdata[MSB_POS];
  assign global_irq_enable_bit = interrupt_control_reg[IRQ_EN_POS];

  // ----------------------------------------------------------------
  // Return sequencing
  // ----------------------------------------------------------------
  // two-cycle return, second stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (ce) begin
      busy_q <= !busy_q && is_return(kind);
    end
  end

  // Ready is low only during first cycle's follow-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_ready <= 1'b1;
    end else if (ce) begin
      instr_ready <= busy_q || !is_return(kind);
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack pop
  // ----------------------------------------------------------------
  // pop stack top into counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q      <= PC_W'(PC_RST);
      pc_load   <= 1'b0;
      stack_pop <= 1'b0;
    end else if (ce) begin
      pc_load   <= 1'b0;
      stack_pop <= 1'b0;
      if (!busy_q && is_return(kind)) begin
        pc_q      <= stack_top_entry;
        pc_load   <= 1'b1;
        stack_pop <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control
  // ----------------------------------------------------------------
  // set enable bit, flags untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_control_reg <= ICTL_RST;
    end else if (ce && !busy_q && kind == OP_RETFI) begin
      interrupt_control_reg[IRQ_EN_POS] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Working register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= W_RST;
    end else if (ce && !busy_q) begin
      if (kind == OP_RETLIT) begin
        w_q <= instr[7:0];
      // destination 0 goes to working register
      end else if (kind == OP_ROTL && !instr[DEST_BIT]) begin
        w_q <= rot_res;
      end
    end
  end

  // ----------------------------------------------------------------
  // File write-back and carry
  // ----------------------------------------------------------------
  // destination 1 writes file, carry only flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_wr  <= '0;
      carry_q  <= 1'b0;
      carry_we <= 1'b0;
    end else if (ce) begin
      file_wr.en <= 1'b0;
      carry_we   <= 1'b0;
      if (!busy_q && kind == OP_ROTL) begin
        file_wr.en   <= instr[DEST_BIT];
        file_wr.addr <= instr[6:0];
        file_wr.data <= rot_res;
        carry_q      <= rot_carry;
        carry_we     <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_ret_start;
    ce && !busy_q && is_return(kind);
  endsequence

  // Return taken, then its second cycle clocked
  sequence s_ret_busy;
    s_ret_start ##1 ce;
  endsequence

  a_pop_loads_pc: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_start |=> (pc_load && stack_pop && pc_q == $past(stack_top_entry)))
    else $error("return did not load stack top");
  a_irq_en_set: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_RETFI) |=> global_irq_enable_bit)
    else $error("interrupt return left enable clear");
  a_ret_two_cyc: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_busy |=> instr_ready)
    else $error("return did not end after two cycles");
  a_busy_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && busy_q) |=> !(pc_load || stack_pop || carry_we || file_wr.en))
    else $error("request taken in busy cycle");
  a_ret_stall: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_start |=> !instr_ready)
    else $error("return did not stall one cycle");
  a_ret_no_carry: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_start |=> !carry_we)
    else $error("return touched carry");
  a_ret_keeps_flags: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_start |=> $stable(carry_q))
    else $error("return changed carry");
  a_lit_to_w: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_RETLIT) |=> w_q == $past(instr[7:0]))
    else $error("literal not in working register");
  a_lit_pops: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_RETLIT) |=> stack_pop && pc_load)
    else $error("literal return did not pop");
  a_ret_one_pop: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_busy |=> !stack_pop && !pc_load)
    else $error("return popped twice");
  a_rot_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_ROTL) |=> carry_q == $past(file_rdata[7]))
    else $error("rotate carry wrong");
  a_rot_w_value: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_ROTL && !instr[DEST_BIT])
    |=> w_q == {$past(file_rdata[MSB_POS-1:0]), $past(carry_in)})
    else $error("rotate result wrong");
  a_rot_dest: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_ROTL) |=> file_wr.en == $past(instr[7]))
    else $error("rotate destination wrong");
  a_rot_one_cyc: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_ROTL) |=> instr_ready && !stack_pop)
    else $error("rotate not single cycle");
  a_rot_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !busy_q && kind == OP_ROTL) |=> file_wr.addr == $past(instr[6:0]))
    else $error("rotate address wrong");
endmodule // return_and_rotate_exec
`default_nettype wire

// ### dv/test_return_and_rotate_exec.sv
/*
  Self-checking bench for the return and rotate execution unit.
  Assumes the unit's package is compiled first; inputs change at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module test_return_and_rotate_exec;
  import ret_rot_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk             = 1'b0;   // 125 MHz clock
  logic        rst_n           = 1'b0;   // Reset, active low
  logic        ce              = 1'b1;   // Clock enable
  logic [13:0] instr           = 14'h0000;
  logic        instr_valid     = 1'b0;
  logic [14:0] stack_top_entry = 15'h0000;
  logic [7:0]  file_rdata      = 8'h00;
  logic        carry_in        = 1'b0;
  logic        instr_ready, stack_pop, pc_load, carry_q, carry_we;
  logic [14:0] pc_q;
  logic [7:0]  w_q, interrupt_control_reg;
  file_wr_t    file_wr;
  logic [31:0] seed            = 32'h89F7; // Random state
  logic [7:0]  w_exp;                      // Expected working register
  logic        irq_en_exp;                 // Expected global enable
  int          miscompares     = 0;
  int          check_count     = 0;

  always #4 clk = ~clk;

  return_and_rotate_exec dut (.clk(clk), .rst_n(rst_n), .ce(ce), .instr(instr),
    .instr_valid(instr_valid), .stack_top_entry(stack_top_entry),
    .file_rdata(file_rdata), .carry_in(carry_in), .instr_ready(instr_ready),
    .stack_pop(stack_pop), .pc_q(pc_q), .pc_load(pc_load), .w_q(w_q),
    .interrupt_control_reg(interrupt_control_reg), .carry_q(carry_q),
    .carry_we(carry_we), .file_wr(file_wr));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Left rotate through carry
  function automatic logic [7:0] rot_exp(input logic [7:0] f, input logic c);
    return {f[6:0], c};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Drop the request for one cycle
  task automatic idle();
    instr_valid = 1'b0;
    @(negedge clk);
  endtask

  // Rotate, driven at a falling edge, checked one cycle later
  task automatic do_rot(input logic d, input logic [6:0] a, input logic [7:0] f, input logic c);
    instr = {ROTL_HI, d, a};
    instr_valid = 1'b1;
    file_rdata = f;
    carry_in = c;
    @(negedge clk);
    chk({carry_we, carry_q}, {1'b1, f[MSB_POS]}, "carry");
    chk({pc_load, stack_pop, instr_ready}, 3'b001, "rot ctl");
    chk(file_wr.en, d, "file en");
    if (d) chk({file_wr.addr, file_wr.data}, {a, rot_exp(f, c)}, "file");
    else w_exp = rot_exp(f, c);
    chk(w_q, w_exp, "w rot");
  endtask

  // Return; hold keeps a rotate pending through the busy cycle
  task automatic do_ret(input logic [13:0] code, input logic hold);
    logic [14:0] ret_addr;
    seed = lfsr_next(seed);
    ret_addr = seed[14:0];
    instr = code;
    instr_valid = 1'b1;
    stack_top_entry = ret_addr;
    @(negedge clk);
    instr_valid = hold;
    instr = {ROTL_HI, 8'h85};
    stack_top_entry = ~ret_addr;
    if (code[13:8] == RETLIT_HI) w_exp = code[7:0];
    if (code == RETFI_CODE) irq_en_exp = 1'b1;
    chk(pc_q, ret_addr, "pc");
    chk({pc_load, stack_pop, instr_ready, carry_we}, 4'b1100, "pop");
    chk(w_q, w_exp, "w ret");
    chk(interrupt_control_reg[IRQ_EN_POS], irq_en_exp, "irq en");
    @(negedge clk);
    chk({pc_load, stack_pop, instr_ready, carry_we, file_wr.en}, 5'b00100, "busy");
    chk(pc_q, ret_addr, "pc hold");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    w_exp = W_RST;
    irq_en_exp = ICTL_RST[IRQ_EN_POS];
    chk({instr_ready, stack_pop, pc_load, carry_we, file_wr.en}, 5'b10000, "rst ctl");
    chk({pc_q, 1'b0}, {PC_RST, 1'b0}, "rst pc");
    chk({w_q, interrupt_control_reg}, {W_RST, ICTL_RST}, "rst regs");
    // Corner cases: back to back rotates, edge values, held request
    do_rot(1'b0, 7'h00, 8'hE6, 1'b0);
    do_rot(1'b1, 7'h7F, 8'h80, 1'b1);
    do_rot(1'b0, 7'h40, 8'h7F, 1'b1);
    idle();
    do_ret(RETURN_CODE, 1'b0);
    do_ret({RETLIT_HI, 8'hFF}, 1'b1);
    idle();
    do_ret(RETFI_CODE, 1'b0);
    do_ret({RETLIT_HI, 8'h00}, 1'b0);
    idle();
    $display("corner tests done");
    // Random mix
    for (int i = 0; i < 60; i++) begin
      seed = lfsr_next(seed);
      case (seed[2:0])
        3'd0:    do_ret(RETURN_CODE, seed[3]);
        3'd1:    do_ret(RETFI_CODE, seed[3]);
        3'd2:    do_ret({RETLIT_HI, seed[15:8]}, seed[3]);
        default: do_rot(seed[3], seed[10:4], seed[18:11], seed[19]);
      endcase
      if (seed[20]) idle();
    end
    idle();
    $display("random tests done");
    // Clock enable low freezes the unit
    ce = 1'b0;
    instr = {ROTL_HI, 8'h01};
    instr_valid = 1'b1;
    file_rdata = 8'h55;
    @(negedge clk);
    chk({carry_we, file_wr.en, stack_pop}, 3'b000, "ce pulses");
    chk(w_q, w_exp, "ce w");
    ce = 1'b1;
    idle();
    $display("enable test done");
    end_of_test();
  end
endmodule // test_return_and_rotate_exec
`default_nettype wire
